/* File: core/sts_branch_eval.sv */
`timescale 1ns/1ps
// Condition of one branch, purely combinational
module sts_branch_eval import sts_pkg::*; (
	input  wire logic                           i_en,
	input  wire sts_branch_t                    i_ctrl,
	input  wire sts_value_t                     i_value,
	input  wire logic [NUM_TRIG-1:0]            i_trig,
	input  wire logic [NUM_RES-1:0][CNT_W-1:0]  i_cnt,
	input  wire logic [NUM_RES-1:0]             i_flags,
	output logic                                o_hit
);
	wire              idx_ok = i_ctrl.cmp_idx < RES_IDX_W'(NUM_RES);
	wire [CNT_W-1:0]  flag_v = CNT_W'(i_flags[i_ctrl.cmp_idx]);
	wire [CNT_W-1:0]  opnd   = !idx_ok ? '0 :
	                           i_ctrl.res_flag ? flag_v : i_cnt[i_ctrl.cmp_idx];
	wire              t_trig = i_trig[i_ctrl.trig_sel] ^ i_ctrl.inv_trig;
	wire              t_cmp  = rel_cmp(i_ctrl.relop, opnd, i_value.cmp_val);
	wire              and_v  = (~i_ctrl.use_trig | t_trig) &
	                           (~i_ctrl.use_cmp | t_cmp);
	wire              or_v   = (i_ctrl.use_trig & t_trig) |
	                           (i_ctrl.use_cmp & t_cmp);
	wire              grp    = (i_ctrl.logic_or ? or_v : and_v) ^
	                           i_ctrl.invert;
	assign o_hit = i_en & i_ctrl.valid & (i_ctrl.always_true | grp);
endmodule : sts_branch_eval

/* File: core/sts_pkg.sv */
package sts_pkg;
	localparam int NUM_STATES = 4;
	localparam int STATE_W    = 2;
	localparam int NUM_BRANCH = 4;
	localparam int BRANCH_W   = 2;
	localparam int NUM_RES    = 20;
	localparam int RES_IDX_W  = 5;
	localparam int CNT_W      = 16;
	localparam int WIDTH_W    = 5;
	localparam int NUM_TRIG   = 8;
	localparam int TRIG_SEL_W = 3;
	localparam int CFG_W      = 21;
	localparam int PF_W       = 16;

	// Byte addresses and pages of the register map
	localparam logic [11:0] CTRL_OFF      = 12'h000;
	localparam logic [11:0] STAT_OFF      = 12'h004;
	localparam logic [11:0] FLAG_INIT_OFF = 12'h008;
	localparam logic [11:0] FLAG_VAL_OFF  = 12'h00c;
	localparam logic [3:0]  CNT_CFG_PAGE  = 4'h1;
	localparam logic [3:0]  CNT_VAL_PAGE  = 4'h2;
	localparam logic [4:0]  PROG_PAGE     = 5'h08;

	// Field positions
	localparam int CTRL_ARM_BIT   = 0;
	localparam int CTRL_STOP_BIT  = 1;
	localparam int STAT_PF_BIT    = 1;
	localparam int STAT_DONE_BIT  = 2;
	localparam int STAT_STATE_LSB = 4;
	localparam int STAT_SEG_LSB   = 8;
	localparam int CFG_WIDTH_LSB  = 16;

	// Values after reset, and the write and read response codes
	localparam logic [NUM_RES-1:0] FLAG_INIT_RST = 20'h00000;
	localparam logic [CFG_W-1:0]   CNT_CFG_RST   = 21'h100000;
	localparam logic [1:0]         AXI_OKAY      = 2'h0;
	localparam logic [1:0]         AXI_SLVERR    = 2'h2;

	typedef enum logic [2:0] {
		REL_GT, REL_GE, REL_EQ, REL_NE, REL_LE, REL_LT
	} sts_relop_t;

	// One branch: condition terms, then its actions
	typedef struct packed {
		logic                 flag_en;
		logic [RES_IDX_W-1:0] act_idx;
		logic                 act_dir;
		logic                 cnt_en;
		logic [STATE_W-1:0]   goto_tgt;
		logic                 goto_en;
		logic                 seg_trig;
		logic                 trig;
		logic                 always_true;
		logic                 invert;
		logic                 logic_or;
		sts_relop_t           relop;
		logic                 use_cmp;
		logic                 res_flag;
		logic [RES_IDX_W-1:0] cmp_idx;
		logic                 inv_trig;
		logic                 use_trig;
		logic [TRIG_SEL_W-1:0] trig_sel;
		logic                 valid;
	} sts_branch_t;

	typedef struct packed {
		logic [PF_W-1:0]  postfill;
		logic [CNT_W-1:0] cmp_val;
	} sts_value_t;

	function automatic logic rel_cmp(sts_relop_t op, logic [CNT_W-1:0] a,
	                                 logic [CNT_W-1:0] b);
		case (op)
			REL_GT:  return a > b;
			REL_GE:  return a >= b;
			REL_EQ:  return a == b;
			REL_NE:  return a != b;
			REL_LE:  return a <= b;
			REL_LT:  return a < b;
			default: return 1'b0;
		endcase
	endfunction : rel_cmp

	function automatic logic [CNT_W-1:0] cnt_max(logic [WIDTH_W-1:0] w);
		logic [CNT_W-1:0] m;
		m = '1;
		if (w != '0 && w < WIDTH_W'(CNT_W))
			m = m >> (WIDTH_W'(CNT_W) - w);
		return m;
	endfunction : cnt_max

	function automatic logic [31:0] lane_merge(logic [31:0] old_v,
	                                           logic [31:0] new_v,
	                                           logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		return r;
	endfunction : lane_merge
endpackage : sts_pkg

/* File: core/sts_prog_mem.sv */
`timescale 1ns/1ps
// Program store, one word pair per state; read data registered
module sts_prog_mem import sts_pkg::*; #(
	parameter int DEPTH  = NUM_STATES,
	parameter int ADDR_W = STATE_W,
	parameter int HALF_W = 32
) (
	input  wire logic                i_clock,
	input  wire logic                i_rstn,
	input  wire logic [1:0]          i_we,
	input  wire logic [ADDR_W-1:0]   i_waddr,
	input  wire logic [HALF_W-1:0]   i_wdata,
	input  wire logic [ADDR_W-1:0]   i_raddr,
	output logic      [2*HALF_W-1:0] o_rdata
);
	logic [2*HALF_W-1:0] mem [DEPTH];

	// Cleared store so an unprogrammed branch never fires
	initial begin
		for (int i = 0; i < DEPTH; i++)
			mem[i] = '0;
	end

	// Each half written on its own lane
	always_ff @(posedge i_clock) begin
		if (i_we[0])
			mem[i_waddr][HALF_W-1:0] <= i_wdata;
		if (i_we[1])
			mem[i_waddr][2*HALF_W-1:HALF_W] <= i_wdata;
	end

	// Registered read port
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn)
			o_rdata <= '0;
		else
			o_rdata <= mem[i_raddr];
	end
endmodule : sts_prog_mem

/* File: core/sts_trigger_seq.sv */
`timescale 1ns/1ps
module sts_trigger_seq import sts_pkg::*; #(
	parameter int NUM_SEG = 4,
	parameter int SEG_W   = 2
) (
	input  wire logic                i_clock,
	input  wire logic                i_rstn,
	input  wire logic [11:0]         i_awaddr,
	input  wire logic                i_awvalid,
	output logic                     o_awready,
	input  wire logic [31:0]         i_wdata,
	input  wire logic [3:0]          i_wstrb,
	input  wire logic                i_wvalid,
	output logic                     o_wready,
	output logic [1:0]               o_bresp,
	output logic                     o_bvalid,
	input  wire logic                i_bready,
	input  wire logic [11:0]         i_araddr,
	input  wire logic                i_arvalid,
	output logic                     o_arready,
	output logic [31:0]              o_rdata,
	output logic [1:0]               o_rresp,
	output logic                     o_rvalid,
	input  wire logic                i_rready,
	input  wire logic [NUM_TRIG-1:0] i_trig,
	output logic                     o_running,
	output logic [STATE_W-1:0]       o_state,
	output logic                     o_acq_stop,
	output logic                     o_seg_close,
	output logic [SEG_W-1:0]         o_seg_index
);
	////////////////////////////////////////////////////////////////////
	logic                 aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic                 awready_q, wready_q, arready_q;
	logic [1:0]           bresp_q, rresp_q;
	logic [31:0]          rdata_q, wdata_q;
	logic [11:0]          awaddr_q;
	logic [3:0]           wstrb_q;
	logic [NUM_RES-1:0]   flag_init_q, flg_q, flg_d;
	logic [NUM_RES-1:0][CFG_W-1:0] cnt_cfg_q;
	logic [NUM_RES-1:0][CNT_W-1:0] cnt_q, cnt_d;
	logic                 running_q, pf_pend_q, pf_seg_q, done_q;
	logic [PF_W-1:0]      pf_cnt_q;
	logic [STATE_W-1:0]   state_q;
	logic [SEG_W-1:0]     seg_q;
	logic                 stop_q, segc_q;

	// Write channel: address and data taken in either order
	wire        aw_hs   = i_awvalid & awready_q;
	wire        w_hs    = i_wvalid & wready_q;
	wire        aw_full = aw_have_q | aw_hs;
	wire        w_full  = w_have_q | w_hs;
	wire        wr_do   = aw_full & w_full & ~bvalid_q;
	wire        bvld_d  = wr_do | (bvalid_q & ~i_bready);
	wire        awh_d   = aw_full & ~wr_do;
	wire        wh_d    = w_full & ~wr_do;
	wire [11:0] wr_addr = aw_have_q ? awaddr_q : i_awaddr;
	wire [31:0] wr_data = w_have_q ? wdata_q : i_wdata;
	wire [3:0]  wr_strb = w_have_q ? wstrb_q : i_wstrb;

	// Write decode
	wire [11:0] wr_word = {wr_addr[11:2], 2'h0};
	wire [RES_IDX_W-1:0] wr_idx = wr_addr[6:2];
	wire        wr_rok  = ~wr_addr[7] & (wr_idx < RES_IDX_W'(NUM_RES));
	wire        wr_ctrl = wr_word == CTRL_OFF;
	wire        wr_fini = wr_word == FLAG_INIT_OFF;
	wire        wr_ccfg = (wr_addr[11:8] == CNT_CFG_PAGE) & wr_rok;
	wire        wr_prog = wr_addr[11:7] == PROG_PAGE;
	wire        wr_ok   = wr_ctrl | wr_fini | wr_ccfg | wr_prog;
	wire [BRANCH_W-1:0] wr_br = wr_addr[6:5];
	wire [STATE_W-1:0]  wr_st = wr_addr[4:3];
	wire        prog_we = wr_do & wr_prog & (wr_strb == 4'hf);
	wire        arm_w   = wr_do & wr_ctrl & wr_strb[0] &
	                      wr_data[CTRL_ARM_BIT];
	wire        stop_w  = wr_do & wr_ctrl & wr_strb[0] &
	                      wr_data[CTRL_STOP_BIT] & ~arm_w;

	// Write handshake state; readies drop while a response waits
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bresp_q   <= AXI_OKAY;
		end else begin
			aw_have_q <= awh_d;
			w_have_q  <= wh_d;
			bvalid_q  <= bvld_d;
			awready_q <= ~awh_d & ~bvld_d;
			wready_q  <= ~wh_d & ~bvld_d;
			if (wr_do)
				bresp_q <= wr_ok ? AXI_OKAY : AXI_SLVERR;
		end
	end

	// Held address and data of a half-arrived write
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			awaddr_q <= '0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else begin
			if (aw_hs)
				awaddr_q <= i_awaddr;
			if (w_hs) begin
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_init_q <= FLAG_INIT_RST;
			cnt_cfg_q   <= {NUM_RES{CNT_CFG_RST}};
		end else if (wr_do & wr_fini) begin
			flag_init_q <= NUM_RES'(lane_merge(32'(flag_init_q),
			                                    wr_data, wr_strb));
		end else if (wr_do & wr_ccfg) begin
			cnt_cfg_q[wr_idx] <= CFG_W'(lane_merge(32'(cnt_cfg_q[wr_idx]),
			                                       wr_data, wr_strb));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel: one word, answer one cycle after the address
	wire        ar_hs   = i_arvalid & arready_q;
	wire        rvld_d  = ar_hs | (rvalid_q & ~i_rready);
	wire [11:0] rd_word = {i_araddr[11:2], 2'h0};
	wire [RES_IDX_W-1:0] rd_idx = i_araddr[6:2];
	wire        rd_rok  = ~i_araddr[7] & (rd_idx < RES_IDX_W'(NUM_RES));
	wire        rd_cfg  = (i_araddr[11:8] == CNT_CFG_PAGE) & rd_rok;
	wire        rd_cval = (i_araddr[11:8] == CNT_VAL_PAGE) & rd_rok;
	wire        rd_prog = i_araddr[11:7] == PROG_PAGE;
	wire [31:0] stat_w  = 32'(running_q) |
	                      (32'(pf_pend_q) << STAT_PF_BIT) |
	                      (32'(done_q) << STAT_DONE_BIT) |
	                      (32'(state_q) << STAT_STATE_LSB) |
	                      (32'(seg_q) << STAT_SEG_LSB);
	wire        rd_ok   = (rd_word == CTRL_OFF) | (rd_word == STAT_OFF) |
	                      (rd_word == FLAG_INIT_OFF) |
	                      (rd_word == FLAG_VAL_OFF) |
	                      rd_cfg | rd_cval | rd_prog;
	wire [31:0] rd_data = (rd_word == STAT_OFF)      ? stat_w :
	                      (rd_word == FLAG_INIT_OFF) ? 32'(flag_init_q) :
	                      (rd_word == FLAG_VAL_OFF)  ? 32'(flg_q) :
	                      rd_cfg  ? 32'(cnt_cfg_q[rd_idx]) :
	                      rd_cval ? 32'(cnt_q[rd_idx]) : 32'h0000_0000;

	// Read handshake and data register
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= AXI_OKAY;
		end else begin
			rvalid_q  <= rvld_d;
			arready_q <= ~rvld_d;
			if (ar_hs) begin
				rdata_q <= rd_data;
				rresp_q <= rd_ok ? AXI_OKAY : AXI_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	logic [NUM_BRANCH-1:0][63:0] prog_word;
	logic [NUM_BRANCH-1:0]       hit;
	logic [STATE_W-1:0]          state_d;

	// program rows read by next state
	for (genvar b = 0; b < NUM_BRANCH; b++) begin : g_br
		wire [1:0] we = {2{prog_we & (wr_br == BRANCH_W'(b))}} &
		                {wr_addr[2], ~wr_addr[2]};
		sts_prog_mem u_mem (
			.i_clock (i_clock),
			.i_rstn  (i_rstn),
			.i_we    (we),
			.i_waddr (wr_st),
			.i_wdata (wr_data),
			.i_raddr (state_d),
			.o_rdata (prog_word[b])
		);
		sts_branch_eval u_eval (
			.i_en    (running_q),
			.i_ctrl  (sts_branch_t'(prog_word[b][31:0])),
			.i_value (sts_value_t'(prog_word[b][63:32])),
			.i_trig  (i_trig),
			.i_cnt   (cnt_q),
			.i_flags (flg_q),
			.o_hit   (hit[b])
		);
	end

	// Lowest true branch index
	function automatic logic [BRANCH_W-1:0] first_hit(
		logic [NUM_BRANCH-1:0] h);
		logic [BRANCH_W-1:0] s;
		s = '0;
		for (int i = NUM_BRANCH - 1; i >= 0; i--)
			if (h[i])
				s = BRANCH_W'(i);
		return s;
	endfunction : first_hit

	wire [BRANCH_W-1:0] sel = first_hit(hit);
	wire                go  = (|hit) & ~arm_w & ~stop_w;
	wire sts_branch_t   act = sts_branch_t'(prog_word[sel][31:0]);
	wire sts_value_t    av  = sts_value_t'(prog_word[sel][63:32]);

	wire trig_act = go & (act.trig | act.seg_trig);
	wire imm      = trig_act & (av.postfill == '0);
	wire pf_fire  = pf_pend_q & (pf_cnt_q == PF_W'(1));
	wire end_pend = pf_fire | (pf_pend_q & trig_act);
	wire stop_evt = (end_pend & ~pf_seg_q) | (imm & act.trig);
	wire seg_evt  = (end_pend & pf_seg_q) | (imm & act.seg_trig & ~act.trig);
	wire seg_wrap = seg_q == SEG_W'(NUM_SEG - 1);

	assign state_d = arm_w ? '0 : (go & act.goto_en) ? act.goto_tgt : state_q;

	// all actions land in one cycle
	always_comb begin
		cnt_d = cnt_q;
		flg_d = flg_q;
		for (int i = 0; i < NUM_RES; i++) begin
			if (arm_w) begin
				cnt_d[i] = cnt_cfg_q[i][CNT_W-1:0];
				flg_d[i] = flag_init_q[i];
			end else if (go & (act.act_idx == RES_IDX_W'(i))) begin
				if (act.cnt_en & act.act_dir & (cnt_q[i] != '0))
					cnt_d[i] = cnt_q[i] - CNT_W'(1);
				else if (act.cnt_en & ~act.act_dir &
				         (cnt_q[i] < cnt_max(cnt_cfg_q[i][CFG_W-1:CFG_WIDTH_LSB])))
					cnt_d[i] = cnt_q[i] + CNT_W'(1);
				if (act.flag_en)
					flg_d[i] = act.act_dir;
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			running_q <= 1'b0;
			state_q   <= '0;
			cnt_q     <= '0;
			flg_q     <= '0;
			done_q    <= 1'b0;
			seg_q     <= '0;
		end else begin
			running_q <= arm_w | (running_q & ~stop_w & ~stop_evt);
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			flg_q     <= flg_d;
			done_q    <= ~arm_w & (done_q | stop_evt);
			if (arm_w)
				seg_q <= '0;
			else if (seg_evt)
				seg_q <= seg_wrap ? '0 : seg_q + SEG_W'(1);
		end
	end

	// Post-fill counter; a new trigger cuts short the pending one
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pf_pend_q <= 1'b0;
			pf_seg_q  <= 1'b0;
			pf_cnt_q  <= '0;
		end else if (arm_w | stop_w | stop_evt) begin
			pf_pend_q <= 1'b0;
		end else if (trig_act & ~imm) begin
			pf_pend_q <= 1'b1;
			pf_seg_q  <= ~act.trig;
			pf_cnt_q  <= av.postfill;
		end else if (end_pend) begin
			pf_pend_q <= 1'b0;
		end else if (pf_pend_q) begin
			pf_cnt_q <= pf_cnt_q - PF_W'(1);
		end
	end

	// Buffer pulses, registered
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			stop_q <= 1'b0;
			segc_q <= 1'b0;
		end else begin
			stop_q <= stop_evt;
			segc_q <= seg_evt;
		end
	end

	assign o_awready   = awready_q;
	assign o_wready    = wready_q;
	assign o_bvalid    = bvalid_q;
	assign o_bresp     = bresp_q;
	assign o_arready   = arready_q;
	assign o_rvalid    = rvalid_q;
	assign o_rdata     = rdata_q;
	assign o_rresp     = rresp_q;
	assign o_running   = running_q;
	assign o_state     = state_q;
	assign o_acq_stop  = stop_q;
	assign o_seg_close = segc_q;
	assign o_seg_index = seg_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	arm_entry_a: assert property (
		arm_w |=> running_q && state_q == '0 && flg_q == $past(flag_init_q))
		else $error("arm did not enter first state");
	arm_cnt_a: assert property (
		arm_w |=> cnt_q[0] == $past(cnt_cfg_q[0][CNT_W-1:0]))
		else $error("arm did not load counter init");
	goto_load_a: assert property (
		go && act.goto_en |=> state_q == $past(act.goto_tgt))
		else $error("jump target not loaded");
	prio_first_a: assert property (
		hit[0] |-> sel == '0)
		else $error("first true branch not chosen");
	idle_hold_a: assert property (
		!running_q && !arm_w |=> $stable(state_q) && $stable(cnt_q))
		else $error("idle sequencer changed state");
	cnt_inc_a: assert property (
		go && act.cnt_en && !act.act_dir && act.act_idx == '0 &&
		cnt_q[0] < cnt_max(cnt_cfg_q[0][CFG_W-1:CFG_WIDTH_LSB])
		|=> cnt_q[0] == $past(cnt_q[0]) + CNT_W'(1))
		else $error("increment not by one");
	cnt_sat_a: assert property (
		running_q |-> cnt_q[0] <= cnt_max(cnt_cfg_q[0][CFG_W-1:CFG_WIDTH_LSB]))
		else $error("counter passed its width limit");
	trig_now_a: assert property (
		imm && act.trig |=> o_acq_stop && !running_q)
		else $error("trigger did not stop capture");
	pf_span_a: assert property (
		trig_act && !imm && act.trig && av.postfill == PF_W'(2)
		##1 (!arm_w && !stop_w && !trig_act)[*2] |=> o_acq_stop)
		else $error("post-fill length wrong");
	seg_wrap_a: assert property (
		seg_evt && seg_wrap && !arm_w |=> seg_q == '0 && o_seg_close)
		else $error("segment index did not wrap");
	together_a: assert property (
		go && act.goto_en && act.flag_en && act.act_idx == '0
		|=> state_q == $past(act.goto_tgt) && flg_q[0] == $past(act.act_dir))
		else $error("actions not concurrent");
	bresp_a: assert property (
		wr_do |=> o_bvalid && !o_awready && !o_wready)
		else $error("write response missing");

	arm_c: cover property (arm_w ##1 running_q);
	goto_c: cover property (go && act.goto_en && act.goto_tgt != state_q);
	seg_c: cover property (o_seg_close && o_seg_index == '0);
	pf_c: cover property (pf_fire && !pf_seg_q ##1 stop_q);
endmodule : sts_trigger_seq

/* File: verification/sts_far_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Far side: monitored nets and capture buffer bookkeeping
module sts_far_model import sts_pkg::*; (
	input  wire logic                i_clock,
	input  wire logic                i_rstn,
	input  wire logic [NUM_TRIG-1:0] i_trig_cmd,
	input  wire logic                i_acq_stop,
	input  wire logic                i_seg_close,
	output logic      [NUM_TRIG-1:0] o_trig,
	output logic      [7:0]          o_stops,
	output logic      [7:0]          o_closes
);
	// Nets follow the command one edge late, like a registered source
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_trig   <= '0;
			o_stops  <= '0;
			o_closes <= '0;
		end else begin
			o_trig   <= i_trig_cmd;
			// Cleared only by reset, so the bench works on differences
			o_stops  <= o_stops + 8'(i_acq_stop);
			o_closes <= o_closes + 8'(i_seg_close);
		end
	end
endmodule : sts_far_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); \
	end \
end
////////////////////////////////////////////////////////////
module tb import sts_pkg::*;;
	typedef struct {
		logic [11:0] a;
		logic        wr;
		logic [31:0] d;
		logic [31:0] q;
		logic [1:0]  r;
	} sts_row_t;

	logic                i_clock = 1'b0;
	logic                i_rstn = 1'b0;
	logic                i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic                i_arvalid = 1'b0, i_rready = 1'b0;
	logic [11:0]         i_awaddr = '0, i_araddr = '0;
	logic [31:0]         i_wdata = '0, o_rdata, rdat;
	logic [3:0]          i_wstrb = 4'hf;
	logic                o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic                o_running, o_acq_stop, o_seg_close;
	logic [1:0]          o_bresp, o_rresp, o_seg_index, rsp, s0;
	logic [STATE_W-1:0]  o_state;
	logic [NUM_TRIG-1:0] i_trig, trig_cmd = '0;
	logic [7:0]          stops, closes, n, got;
	logic [5:0]          hit = 6'b010110;
	sts_branch_t         br;
	int                  mismatches = 0, num_checks = 0, cycles = 0, d0, d2;
	// Register rows: address, write?, data, read-back, response
	sts_row_t            rows[6] = '{
		'{12'h104, 1'b0, 32'h0, 32'h00100000, AXI_OKAY},
		'{FLAG_INIT_OFF, 1'b1, 32'h000a5, 32'h000a5, AXI_OKAY},
		'{12'h100, 1'b1, 32'h00020001, 32'h00020001, AXI_OKAY},
		'{12'h010, 1'b1, 32'h1, 32'h0, AXI_SLVERR},
		'{STAT_OFF, 1'b0, 32'h0, 32'h0, AXI_OKAY},
		'{CTRL_OFF, 1'b0, 32'h0, 32'h0, AXI_OKAY}
	};

	sts_trigger_seq sts_trigger_seq_inst (
		.i_clock, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
		.i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
		.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
		.i_rready, .i_trig, .o_running, .o_state, .o_acq_stop,
		.o_seg_close, .o_seg_index
	);
	sts_far_model sts_far_model_inst (
		.i_clock, .i_rstn, .i_trig_cmd(trig_cmd), .i_acq_stop(o_acq_stop),
		.i_seg_close(o_seg_close), .o_trig(i_trig), .o_stops(stops),
		.o_closes(closes)
	);

	// 125 MHz clock and a ceiling well above the planned run
	always #4 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// Write: address and data offered together, each dropped once taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d,
	                   output logic [1:0] r);
		@(posedge i_clock);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			r = o_bresp;
		end while (!o_bvalid);
		i_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] q,
	                   output logic [1:0] r);
		@(posedge i_clock);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_arready) i_arvalid <= 1'b0;
			q = o_rdata;
			r = o_rresp;
		end while (!o_rvalid);
		i_rready <= 1'b0;
	endtask : axr

	// Control word and value word of one branch of one state
	task automatic prog(input int s, input int b, input sts_branch_t c,
	                    input logic [31:0] v);
		logic [11:0] a;
		a = 12'h400 + 12'(32 * b + 8 * s);
		axw(a, c, rsp);
		axw(a + 12'h004, v, rsp);
	endtask : prog

	// Arm, offer one match pattern for a sample, count end pulses
	task automatic run(input sts_branch_t c, input logic [31:0] v,
	                   input logic [7:0] m, output logic [7:0] k);
		prog(0, 0, c, v);
		n = stops;
		axw(CTRL_OFF, 32'h1, rsp);
		trig_cmd <= m;
		@(posedge i_clock);
		trig_cmd <= 8'h00;
		repeat (5) @(posedge i_clock);
		k = stops - n;
		axw(CTRL_OFF, 32'h2, rsp);
	endtask : run

	// Cycles from a one-sample match to the end of capture
	// A match that stays high would cut its own post-fill short
	task automatic lat(input logic [15:0] pf, output int d);
		br = '{valid: 1'b1, use_trig: 1'b1, trig: 1'b1, relop: REL_GT,
		       default: '0};
		prog(0, 0, br, {pf, 16'h0});
		axw(CTRL_OFF, 32'h1, rsp);
		n = stops;
		trig_cmd <= 8'h01;
		@(posedge i_clock);
		trig_cmd <= 8'h00;
		d = 0;
		while (stops == n) begin
			@(posedge i_clock);
			d++;
		end
	endtask : lat

	initial begin
		repeat (12) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(posedge i_clock);
		`CHK({o_running, o_state, o_seg_index}, 5'h00)
		foreach (rows[k]) begin
			if (rows[k].wr) begin
				axw(rows[k].a, rows[k].d, rsp);
				`CHK(rsp, rows[k].r)
			end
			axr(rows[k].a, rdat, rsp);
			`CHK(rdat, rows[k].q)
			`CHK(rsp, rows[k].r)
		end
		// Counter 0 is two bits wide from 1; inc, dec with jump, compare
		br = '{valid: 1'b1, use_trig: 1'b1, cnt_en: 1'b1, relop: REL_GT,
		       default: '0};
		prog(0, 0, br, 32'h0);
		br.trig_sel = 3'd1;
		br.act_dir = 1'b1;
		br.goto_en = 1'b1;
		br.goto_tgt = 2'd1;
		br.flag_en = 1'b1;
		prog(0, 1, br, 32'h0);
		br = '{valid: 1'b1, use_cmp: 1'b1, trig: 1'b1, relop: REL_EQ,
		       default: '0};
		prog(1, 0, br, 32'h2);
		axw(CTRL_OFF, 32'h1, rsp);
		axr(FLAG_VAL_OFF, rdat, rsp);
		`CHK(rdat, 32'h000a5)
		// Both matches high: the first branch must win every sample
		trig_cmd <= 8'h03;
		repeat (4) @(posedge i_clock);
		trig_cmd <= 8'h00;
		axr(12'h200, rdat, rsp);
		`CHK(rdat, 32'h3)
		`CHK(o_state, 2'd0)
		n = stops;
		trig_cmd <= 8'h02;
		@(posedge i_clock);
		trig_cmd <= 8'h00;
		repeat (6) @(posedge i_clock);
		`CHK(o_state, 2'd1)
		`CHK(stops - n, 8'h1)
		axr(12'h200, rdat, rsp);
		`CHK(rdat, 32'h2)
		// Every relational code against counter value 1
		for (int op = 0; op < 6; op++) begin
			br = '{valid: 1'b1, use_cmp: 1'b1, trig: 1'b1,
			       relop: sts_relop_t'(op), default: '0};
			run(br, 32'h1, 8'h00, got);
			`CHK(got, {7'h0, hit[op]})
		end
		// Match OR a false flag test fires; AND does not; NOT of AND does
		br = '{valid: 1'b1, use_trig: 1'b1, use_cmp: 1'b1, res_flag: 1'b1,
		       cmp_idx: 5'd1, logic_or: 1'b1, trig: 1'b1, relop: REL_EQ,
		       default: '0};
		run(br, 32'h5, 8'h01, got);
		`CHK(got, 8'h1)
		br.logic_or = 1'b0;
		run(br, 32'h5, 8'h01, got);
		`CHK(got, 8'h0)
		br.invert = 1'b1;
		run(br, 32'h5, 8'h00, got);
		`CHK(got, 8'h1)
		// Default branch fires with no condition at all
		br = '{valid: 1'b1, always_true: 1'b1, trig: 1'b1, relop: REL_GT,
		       default: '0};
		run(br, 32'h0, 8'h00, got);
		`CHK(got, 8'h1)
		lat(16'h0, d0);
		lat(16'h2, d2);
		`CHK(d2 - d0, 2)
		// Five segment closes on four segments wrap the index once
		br = '{valid: 1'b1, use_trig: 1'b1, trig_sel: 3'd2, seg_trig: 1'b1,
		       relop: REL_GT, default: '0};
		prog(0, 0, br, 32'h0);
		axw(CTRL_OFF, 32'h1, rsp);
		n = closes;
		trig_cmd <= 8'h04;
		repeat (2) @(posedge i_clock);
		s0 = o_seg_index;
		repeat (3) @(posedge i_clock);
		trig_cmd <= 8'h00;
		repeat (4) @(posedge i_clock);
		`CHK(closes - n, 8'h5)
		`CHK(o_seg_index, s0 + 2'd1)
		`CHK(o_running, 1'b1)
		// Reset in mid-run clears the run, the handshakes and the flag init register
		i_rstn <= 1'b0;
		@(posedge i_clock);
		`CHK({o_running, o_seg_index, o_bvalid, o_rvalid}, 5'h00)
		i_rstn <= 1'b1;
		@(posedge i_clock);
		axr(FLAG_INIT_OFF, rdat, rsp);
		`CHK(rdat, 32'h0)
		print_verdict();
	end
endmodule : tb
